// *** mrp_consts.vh ***
// Constants for the motor reference profiler.
// Assumes inclusion by bare name from the same folder.
`ifndef MRP_CONSTS_VH
`define MRP_CONSTS_VH
`define MRP_SRC_ANALOG   2'h0
`define MRP_SRC_PWM      2'h1
`define MRP_SRC_I2C      2'h2
`define MRP_SRC_FREQ     2'h3
`define MRP_PROF_DIRECT  2'h0
`define MRP_PROF_LINEAR  2'h1
`define MRP_PROF_STAIR   2'h2
`define MRP_KIND_SPEED   2'h0
`define MRP_KIND_POWER   2'h1
`define MRP_KIND_CURRENT 2'h2
`define MRP_KIND_VOLTAGE 2'h3
`define MRP_FULL         8'hff
`define MRP_ZERO8        8'h00
`define MRP_CLK_HZ       20000000
`define MRP_FS_DIV       8'hff
`define MRP_RANGE_W      2
`define MRP_CNT_W        24
`endif

// *** mrp_interp.v ***
// Linear interpolation between two breakpoint pairs on an 8-bit scale.
// Assumes x0 <= x <= x1; the caller selects the segment.
`timescale 1ns/1ps
`default_nettype none
module mrp_interp
(
  input  wire [7:0] x,
  input  wire [7:0] x0,
  input  wire [7:0] x1,
  input  wire [7:0] y0,
  input  wire [7:0] y1,
  output reg  [7:0] y
);
  reg [8:0]  dx;
  reg [8:0]  dy;
  reg [17:0] prod;
  reg [17:0] quo;
  reg [9:0]  sum;
  always @*
  begin
    dx   = {1'b0, x1} - {1'b0, x0};
    dy   = {1'b0, y1} - {1'b0, y0};
    prod = 18'h0;
    quo  = 18'h0;
    sum  = {2'b00, y0};
    if (dx != 9'h0)
    begin
      // Signed slope handled by sign of dy; falling segments are legal.
      if (y1 >= y0)
      begin
        prod = {1'b0, x - x0} * dy;
        quo  = prod / {9'h0, dx};
        sum  = {2'b00, y0} + quo[9:0];
      end
      else
      begin
        prod = {1'b0, x - x0} * ({1'b0, y0} - {1'b0, y1});
        quo  = prod / {9'h0, dx};
        sum  = {2'b00, y0} - quo[9:0];
      end
    end
    y = sum[7:0];
  end
endmodule // mrp_interp
`default_nettype wire

// *** mrp_profiler.v ***
// Motor reference profiler: command capture, duty mapping, profile, scaling.
// Assumes one clock domain; the command pin and analog code are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "mrp_consts.vh"
module mrp_profiler
#(
  parameter CNT_W = `MRP_CNT_W,
  parameter LIM_W = 16
)
(
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  wire             cmd_pin,
  input  wire [7:0]       analog_code,
  input  wire [1:0]       source_sel,
  input  wire [1:0]       range_sel,
  input  wire [1:0]       profile_sel,
  input  wire [1:0]       ref_kind,
  input  wire             standby_device,
  input  wire [7:0]       digital_cmd,
  input  wire [7:0]       entry_thr,
  input  wire [7:0]       exit_thr,
  input  wire [7:0]       digital_sb_thr,
  input  wire [CNT_W-1:0] max_freq_period,
  input  wire [CNT_W-1:0] entry_freq_period,
  input  wire [CNT_W-1:0] exit_freq_period,
  input  wire [CNT_W-1:0] sleep_entry_cycles,
  input  wire [7:0]       low_off_breakpoint,
  input  wire [7:0]       low_on_breakpoint,
  input  wire [7:0]       low_off_level,
  input  wire [7:0]       low_clamp_breakpoint,
  input  wire [7:0]       low_clamp_level,
  input  wire [39:0]      bp_duty,
  input  wire [39:0]      bp_level,
  input  wire [7:0]       high_clamp_breakpoint,
  input  wire [7:0]       high_clamp_level,
  input  wire [7:0]       high_off_breakpoint,
  input  wire [7:0]       high_on_breakpoint,
  input  wire [7:0]       high_off_level,
  input  wire [7:0]       step_hysteresis_width,
  input  wire [LIM_W-1:0] full_scale_limit,
  output reg  [7:0]       duty_cmd_r,
  output reg  [7:0]       ref_x_r,
  output reg  [LIM_W-1:0] ref_out_r,
  output reg              motor_run_r,
  output reg              sleep_r,
  output reg              standby_r
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg       pin_s1_r;
  reg       pin_s2_r;
  reg       pin_d_r;
  reg [7:0] ana_s1_r;
  reg [7:0] ana_s2_r;
  always @(posedge clk)
  begin
    if (rst)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r  <= 1'b0;
      ana_s1_r <= `MRP_ZERO8;
      ana_s2_r <= `MRP_ZERO8;
    end
    else if (ce)
    begin
      pin_s1_r <= cmd_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
      ana_s1_r <= analog_code;
      ana_s2_r <= ana_s1_r;
    end
  end
  wire rise = pin_s2_r & ~pin_d_r;

  // ----------------------------------------------------------------
  // Period and high-time measurement
  // ----------------------------------------------------------------
  // Range select prescales the counters so slow inputs do not overflow.
  reg  [7:0]       pre_r;
  reg  [CNT_W-1:0] per_cnt_r;
  reg  [CNT_W-1:0] hi_cnt_r;
  reg  [CNT_W-1:0] period_r;
  reg  [CNT_W-1:0] high_r;
  reg              meas_ok_r;
  reg              new_meas_r;
  wire [7:0]       pre_lim = (8'h01 << {range_sel, 1'b0}) - 8'h01;
  wire             tick = (pre_r >= pre_lim);
  wire             sat = &per_cnt_r;
  always @(posedge clk)
  begin
    if (rst)
    begin
      pre_r      <= 8'h00;
      per_cnt_r  <= {CNT_W{1'b0}};
      hi_cnt_r   <= {CNT_W{1'b0}};
      period_r   <= {CNT_W{1'b0}};
      high_r     <= {CNT_W{1'b0}};
      meas_ok_r  <= 1'b0;
      new_meas_r <= 1'b0;
    end
    else if (ce)
    begin
      new_meas_r <= 1'b0;
      pre_r      <= tick ? 8'h00 : pre_r + 8'h01;
      if (rise)
      begin
        period_r   <= per_cnt_r;
        high_r     <= hi_cnt_r;
        meas_ok_r  <= 1'b1;
        new_meas_r <= 1'b1;
        // The edge cycle is the first count of the new period, and the pin is high in it.
        per_cnt_r  <= {{(CNT_W-1){1'b0}}, 1'b1};
        hi_cnt_r   <= {{(CNT_W-1){1'b0}}, 1'b1};
        pre_r      <= 8'h00;
      end
      else if (tick)
      begin
        if (!sat)
          per_cnt_r <= per_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        else
          meas_ok_r <= 1'b0; // Stuck pin: treated as 0 Hz.
        if (pin_s2_r && !sat)
          hi_cnt_r <= hi_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
  wire pin_level = pin_s2_r;

  // ----------------------------------------------------------------
  // Raw command to duty command
  // ----------------------------------------------------------------
  reg [CNT_W+7:0] num;
  reg [CNT_W+7:0] q;
  reg [7:0]       raw;
  reg [7:0]       duty_nxt;
  reg [8:0]       span;
  reg [16:0]      scl;
  reg [15:0]      dq;
  always @*
  begin
    dq   = 16'h0;
    num  = {(CNT_W+8){1'b0}};
    q    = {(CNT_W+8){1'b0}};
    raw  = `MRP_ZERO8;
    scl  = 17'h0;
    span = 9'h0;
    duty_nxt = duty_cmd_r;
    case (source_sel)
      `MRP_SRC_ANALOG:
        raw = ana_s2_r;
      `MRP_SRC_PWM:
      begin
        if (meas_ok_r && period_r != {CNT_W{1'b0}})
        begin
          num = {high_r, 8'h00} - {8'h00, high_r};
          q   = num / {8'h00, period_r};
          raw = (q > {{CNT_W{1'b0}}, `MRP_FULL}) ? `MRP_FULL : q[7:0];
        end
        else
          raw = pin_level ? `MRP_FULL : `MRP_ZERO8;
      end
      `MRP_SRC_I2C:
        raw = digital_cmd;
      default:
      begin
        // Frequency mode: periods shorter than the maximum clamp to full scale.
        if (!meas_ok_r || period_r >= entry_freq_period)
          raw = `MRP_ZERO8;
        else if (period_r <= max_freq_period)
          raw = `MRP_FULL;
        else
        begin
          num = {exit_freq_period - period_r, 8'h00};
          q   = num / {8'h00, exit_freq_period - max_freq_period};
          raw = (period_r >= exit_freq_period) ? `MRP_ZERO8 :
                (q > {{CNT_W{1'b0}}, `MRP_FULL}) ? `MRP_FULL : q[7:0];
        end
      end
    endcase
    // The register value is the duty command itself; it has its own standby threshold.
    if (source_sel == `MRP_SRC_FREQ || source_sel == `MRP_SRC_I2C)
      duty_nxt = raw;
    else if (raw <= entry_thr)
      duty_nxt = `MRP_ZERO8;
    else if (raw >= exit_thr)
    begin
      span = {1'b0, `MRP_FULL} - {1'b0, exit_thr};
      scl  = {1'b0, raw - exit_thr, 8'h00} - {9'h0, raw - exit_thr};
      dq   = scl[15:0] / {7'h0, span};
      duty_nxt = (span == 9'h0) ? `MRP_FULL : dq[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Sleep and standby supervision
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] zero_cnt_r;
  wire            zero_long = (zero_cnt_r >= sleep_entry_cycles);
  wire            is_i2c = (source_sel == `MRP_SRC_I2C);
  always @(posedge clk)
  begin
    if (rst)
      zero_cnt_r <= {CNT_W{1'b0}};
    else if (ce)
    begin
      if (duty_nxt != `MRP_ZERO8)
        zero_cnt_r <= {CNT_W{1'b0}};
      else if (!zero_long)
        zero_cnt_r <= zero_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Profile engine
  // ----------------------------------------------------------------
  reg  [7:0]  lo_off_r;
  reg  [7:0]  hi_off_r;
  reg  [2:0]  step_r;
  wire [47:0] px = {high_clamp_breakpoint, bp_duty};
  wire [47:0] py = {high_clamp_level, bp_level};
  wire [7:0]  seg_x0 [0:5];
  wire [7:0]  seg_x1 [0:5];
  wire [7:0]  seg_y0 [0:5];
  wire [7:0]  seg_y1 [0:5];
  wire [7:0]  seg_y  [0:5];
  wire [5:0]  seg_hit;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_seg
      if (g == 0)
      begin : g_first
        assign seg_x0[g] = low_clamp_breakpoint;
        assign seg_y0[g] = low_clamp_level;
      end
      else
      begin : g_rest
        assign seg_x0[g] = px[8*g-1 -: 8];
        assign seg_y0[g] = py[8*g-1 -: 8];
      end
      assign seg_x1[g]  = px[8*g+7 -: 8];
      assign seg_y1[g]  = py[8*g+7 -: 8];
      assign seg_hit[g] = (duty_cmd_r > seg_x0[g]) && (duty_cmd_r <= seg_x1[g]);
      mrp_interp u_interp
      (
        .x  (duty_cmd_r),
        .x0 (seg_x0[g]),
        .x1 (seg_x1[g]),
        .y0 (seg_y0[g]),
        .y1 (seg_y1[g]),
        .y  (seg_y[g])
      );
    end
  endgenerate

  // Staircase level index: 0 low clamp, 1..5 A..E, 6 high clamp.
  reg [2:0] step_nxt;
  reg [7:0] up_bp;
  reg [7:0] dn_bp;
  always @*
  begin
    step_nxt = step_r;
    up_bp = (step_r == 3'h0) ? low_clamp_breakpoint : px[8*step_r-1 -: 8];
    dn_bp = (step_r <= 3'h1) ? low_clamp_breakpoint : px[8*step_r-9 -: 8];
    if (step_r < 3'h6 && duty_cmd_r > up_bp)
      step_nxt = step_r + 3'h1;
    else if (step_r != 3'h0 && {1'b0, duty_cmd_r} + {1'b0, step_hysteresis_width} <
             {1'b0, dn_bp})
      step_nxt = step_r - 3'h1;
  end

  reg [7:0] prof;
  reg [7:0] lin;
  integer   k;
  always @*
  begin
    lin = high_clamp_level;
    if (duty_cmd_r <= low_clamp_breakpoint)
      lin = low_clamp_level;
    for (k = 0; k < 6; k = k + 1)
      if (seg_hit[k])
        lin = seg_y[k];
    case (profile_sel)
      `MRP_PROF_DIRECT: prof = duty_cmd_r;
      `MRP_PROF_LINEAR: prof = lin;
      `MRP_PROF_STAIR:
        prof = (step_r == 3'h0) ? low_clamp_level : py[8*step_r-1 -: 8];
      default: prof = duty_cmd_r;
    endcase
    if (profile_sel == `MRP_PROF_LINEAR || profile_sel == `MRP_PROF_STAIR)
    begin
      if (lo_off_r != 8'h00)
        prof = low_off_level;
      else if (hi_off_r != 8'h00)
        prof = high_off_level;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  reg  [7:0]        ref_nxt;
  reg               run_nxt;
  wire [LIM_W+7:0]  prod = ref_nxt * full_scale_limit;
  wire [LIM_W+7:0]  scaled = prod / {{LIM_W{1'b0}}, `MRP_FS_DIV};
  always @*
  begin
    ref_nxt = prof;
    run_nxt = 1'b1;
    if (duty_cmd_r == `MRP_ZERO8)
    begin
      // A zero command overrides every profile.
      if (standby_device)
        ref_nxt = low_off_level;
      else
      begin
        ref_nxt = `MRP_ZERO8;
        run_nxt = 1'b0;
      end
    end
    if (sleep_r)
    begin
      ref_nxt = `MRP_ZERO8;
      run_nxt = 1'b0;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      duty_cmd_r  <= `MRP_ZERO8;
      ref_x_r     <= `MRP_ZERO8;
      ref_out_r   <= {LIM_W{1'b0}};
      motor_run_r <= 1'b0;
      sleep_r     <= 1'b0;
      standby_r   <= 1'b0;
      lo_off_r    <= 8'h01;
      hi_off_r    <= 8'h00;
      step_r      <= 3'h0;
    end
    else if (ce)
    begin
      if (source_sel == `MRP_SRC_ANALOG || source_sel == `MRP_SRC_I2C || new_meas_r ||
          !meas_ok_r)
        duty_cmd_r <= duty_nxt;
      if (duty_cmd_r < low_off_breakpoint)
        lo_off_r <= 8'h01;
      else if (duty_cmd_r >= low_on_breakpoint)
        lo_off_r <= 8'h00;
      if (duty_cmd_r > high_off_breakpoint)
        hi_off_r <= 8'h01;
      else if (duty_cmd_r <= high_on_breakpoint)
        hi_off_r <= 8'h00;
      step_r <= step_nxt;
      if (is_i2c)
      begin
        if (!pin_level && zero_long && digital_cmd == `MRP_ZERO8)
          sleep_r <= 1'b1;
        else if (pin_level)
          sleep_r <= 1'b0;
        standby_r <= pin_level && (digital_cmd <= digital_sb_thr);
      end
      else
      begin
        sleep_r   <= 1'b0;
        standby_r <= (duty_cmd_r == `MRP_ZERO8) && standby_device;
      end
      ref_x_r     <= ref_nxt;
      motor_run_r <= run_nxt;
      if (ref_kind == `MRP_KIND_VOLTAGE)
        ref_out_r <= {{(LIM_W-8){1'b0}}, ref_nxt};
      else
        ref_out_r <= scaled[LIM_W-1:0];
    end
  end
endmodule // mrp_profiler
`default_nettype wire

// *** mrp_profiler_properties.sv ***
// Concurrent checks on the ports of the motor reference profiler.
// Assumes one clock, synchronous active-high reset and the clock enable held high.
`timescale 1ns/1ps
`default_nettype none
module mrp_profiler_properties
#(
  parameter CNT_W = 24,
  parameter LIM_W = 16
)
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             ce,
  input wire logic             cmd_pin,
  input wire logic [1:0]       source_sel,
  input wire logic [1:0]       profile_sel,
  input wire logic [1:0]       ref_kind,
  input wire logic             standby_device,
  input wire logic [7:0]       digital_cmd,
  input wire logic [7:0]       digital_sb_thr,
  input wire logic [CNT_W-1:0] sleep_entry_cycles,
  input wire logic [7:0]       low_off_breakpoint,
  input wire logic [7:0]       low_off_level,
  input wire logic [7:0]       high_off_breakpoint,
  input wire logic [7:0]       high_off_level,
  input wire logic [LIM_W-1:0] full_scale_limit,
  input wire logic [7:0]       duty_cmd_r,
  input wire logic [7:0]       ref_x_r,
  input wire logic [LIM_W-1:0] ref_out_r,
  input wire logic             motor_run_r,
  input wire logic             sleep_r
);
  logic [2:0]       up_r;
  logic [CNT_W-1:0] zc_r;
  logic [31:0]      prod_w;
  logic [31:0]      outs_w;
  assign prod_w = ref_x_r * full_scale_limit;
  assign outs_w = ref_out_r * 32'hff;
  // The up counter keeps checks off the first edges after reset, when outputs still hold zero.
  always @(posedge clk)
  begin
    if (rst)
    begin
      up_r <= 3'h0;
      zc_r <= {CNT_W{1'b0}};
    end
    else
    begin
      if (up_r != 3'h7)
        up_r <= up_r + 3'h1;
      if (source_sel != 2'h2 || digital_cmd != 8'h00)
        zc_r <= {CNT_W{1'b0}};
      else if (~&zc_r)
        zc_r <= zc_r + 1'b1;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_reset_clears: assert property (disable iff (1'b0) rst && ce |=> duty_cmd_r == 8'h00 && ref_x_r == 8'h00 && ref_out_r == 0 && !motor_run_r && !sleep_r)
    else $error("outputs not cleared by reset");
  chk_direct_pass: assert property (profile_sel == 2'h0 && $past(profile_sel) == 2'h0 && $past(profile_sel, 2) == 2'h0 && duty_cmd_r != 8'h00 && $past(duty_cmd_r) == duty_cmd_r && up_r == 3'h7 |-> ref_x_r == duty_cmd_r)
    else $error("direct profile output differs from duty command");
  chk_scaled_ref: assert property (ref_kind != 2'h3 && $past(ref_kind) == ref_kind && $past(ref_x_r) == ref_x_r && $stable(full_scale_limit) && up_r == 3'h7 |-> prod_w + 32'hff >= outs_w && prod_w < outs_w + 32'h1fe)
    else $error("scaled reference off the limit ratio");
  chk_voltage_ref: assert property (ref_kind == 2'h3 && $past(ref_kind) == 2'h3 && $past(ref_x_r) == ref_x_r && up_r == 3'h7 |-> ref_out_r == ref_x_r)
    else $error("voltage reference not equal to profiler output");
  chk_i2c_duty: assert property (source_sel == 2'h2 && $past(source_sel) == 2'h2 && $past(source_sel, 2) == 2'h2 && digital_cmd > digital_sb_thr && $past(digital_cmd) == digital_cmd && $past(digital_cmd, 2) == digital_cmd && up_r == 3'h7 |-> duty_cmd_r == digital_cmd)
    else $error("duty command not taken from the register");
  chk_zero_stop: assert property (!standby_device && !$past(standby_device) && duty_cmd_r == 8'h00 && $past(duty_cmd_r) == 8'h00 && $past(duty_cmd_r, 2) == 8'h00 && up_r == 3'h7 |-> !motor_run_r)
    else $error("motor runs on zero command");
  chk_standby_level: assert property (standby_device && $past(standby_device) && duty_cmd_r == 8'h00 && $past(duty_cmd_r) == 8'h00 && $past(duty_cmd_r, 2) == 8'h00 && up_r == 3'h7 |-> motor_run_r && ref_x_r == low_off_level)
    else $error("standby zero command not at low off level");
  chk_high_off: assert property (profile_sel == 2'h1 && $past(profile_sel) == 2'h1 && $past(profile_sel, 2) == 2'h1 && duty_cmd_r > high_off_breakpoint && $past(duty_cmd_r) == duty_cmd_r && $past(duty_cmd_r, 2) == duty_cmd_r |-> ref_x_r == high_off_level)
    else $error("high off level missing above breakpoint");
  chk_low_off: assert property (profile_sel == 2'h1 && $past(profile_sel) == 2'h1 && $past(profile_sel, 2) == 2'h1 && duty_cmd_r != 8'h00 && duty_cmd_r < low_off_breakpoint && $past(duty_cmd_r) == duty_cmd_r && $past(duty_cmd_r, 2) == duty_cmd_r |-> ref_x_r == low_off_level)
    else $error("low off level missing below breakpoint");
  chk_sleep_delay: assert property ($rose(sleep_r) |-> zc_r + 2 >= sleep_entry_cycles && digital_cmd == 8'h00)
    else $error("sleep entered before the delay ran out");
  chk_wake_exit: assert property (sleep_r && cmd_pin |-> ##[1:6] !sleep_r)
    else $error("sleep not left after pin rose");
endmodule // mrp_profiler_properties
bind mrp_profiler mrp_profiler_properties #(.CNT_W(CNT_W), .LIM_W(LIM_W)) u_chk (.*);
`default_nettype wire

// *** mrp_host_model.sv ***
// Host partner: drives the command pin as a PWM or square wave.
// Assumes the bench sets high time and period; between runs the pin rests at a level.
`timescale 1ns/1ps
`default_nettype none
module mrp_host_model
(
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic        idle_level,
  input  wire logic [23:0] high_cycles,
  input  wire logic [23:0] period_cycles,
  output var  logic        cmd_pin = 1'b1
);
  logic [23:0] phase_r = 24'h0;
  // Low time at the smallest duty stays well under the sleep delay.
  always @(posedge clk)
  begin
    if (!run || phase_r + 24'h1 >= period_cycles)
      phase_r <= 24'h0;
    else
      phase_r <= phase_r + 24'h1;
    cmd_pin <= run ? (phase_r < high_cycles) : idle_level;
  end
endmodule // mrp_host_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the motor reference profiler.
// Assumes the profiler with its default counter widths and a host model on the pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, standby_device = 1'b0, run = 1'b0, idle = 1'b1;
  wire logic   cmd_pin;
  logic [1:0]  source_sel = 2'h2, range_sel = 2'h0, profile_sel = 2'h0, ref_kind = 2'h3;
  logic [7:0]  analog_code = 8'h00, digital_cmd = 8'h00, entry_thr = 8'h04, exit_thr = 8'h04;
  logic [7:0]  digital_sb_thr = 8'h05, low_off_breakpoint = 8'h14, low_on_breakpoint = 8'h1e;
  logic [7:0]  low_off_level = 8'h03, low_clamp_breakpoint = 8'h28, low_clamp_level = 8'h0a;
  logic [7:0]  high_clamp_breakpoint = 8'ha0, high_clamp_level = 8'h96, high_off_level = 8'h05;
  logic [7:0]  high_off_breakpoint = 8'hdc, high_on_breakpoint = 8'hc8;
  logic [7:0]  step_hysteresis_width = 8'h08, duty_cmd_r, ref_x_r, v;
  // Breakpoints ascend, with the clamps inside the off points.
  logic [39:0] bp_duty = 40'h8c7864503c, bp_level = 40'h826e5a4632;
  logic [23:0] max_freq_period = 24'h64, entry_freq_period = 24'h7d0, exit_freq_period = 24'h5dc;
  logic [23:0] sleep_entry_cycles = 24'hc8, hi = 24'h1, per = 24'h64;
  logic [15:0] full_scale_limit = 16'h3e8, ref_out_r;
  logic        motor_run_r, sleep_r, standby_r;
  int          failures = 0, checks_done = 0, pct;
  logic [23:0] tbl [15] = '{24'h01e605, 24'h01d205, 24'h01be96, 24'h01190a, 24'h010f03,
    24'h011903, 24'h01230a, 24'h023232, 24'h024646, 24'h025a5a, 24'h026e6e, 24'h028282,
    24'h029696, 24'h028a96, 24'h027e82};
  mrp_profiler dut (.*);
  mrp_host_model host (.clk(clk), .run(run), .idle_level(idle), .high_cycles(hi),
    .period_cycles(per), .cmd_pin(cmd_pin));
  initial
    forever #25 clk = ~clk;
  task automatic cmp(input string what, input logic [15:0] exp, got, tol);
    checks_done++;
    if ($isunknown(got) || 32'(got) + tol < exp || got > 32'(exp) + tol)
    begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic cmpb(input string what, input logic exp, got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Eight cycles cover duty, reference and hysteresis stages with margin.
  task automatic put(input logic [7:0] d);
    digital_cmd = d;
    wait_n(8);
  endtask
  function automatic logic [7:0] lin(input logic [7:0] d);
    logic [55:0] xs;
    logic [55:0] ys;
    int          x0, x1, y0, y1;
    xs = {high_clamp_breakpoint, bp_duty, low_clamp_breakpoint};
    ys = {high_clamp_level, bp_level, low_clamp_level};
    lin = high_clamp_level;
    for (int i = 5; i >= 0; i--)
    begin
      x0 = xs[i*8 +: 8];
      x1 = xs[i*8+8 +: 8];
      y0 = ys[i*8 +: 8];
      y1 = ys[i*8+8 +: 8];
      if (d < x1)
        lin = 8'(y0 + (d - x0) * (y1 - y0) / (x1 - x0));
    end
  endfunction
  function automatic logic [15:0] scaled(input logic [7:0] x);
    scaled = (ref_kind == 2'h3) ? {8'h00, x} : 16'((32'(x) * full_scale_limit) / 255);
  endfunction
  function automatic logic [7:0] pwm_exp(input int p);
    pwm_exp = 8'(((p * 255 / 100) - exit_thr) * 255 / (255 - exit_thr));
  endfunction
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    complete_run;
  end
  initial
  begin
    void'($urandom(31271));
    wait_n(20);
    rst = 1'b0;
    for (int k = 0; k < 12; k++)
    begin
      ref_kind = k[1:0];
      full_scale_limit = 16'($urandom);
      v = 8'($urandom_range(255, 6));
      put(v);
      cmp("duty", v, duty_cmd_r, 16'h0);
      cmp("refx", v, ref_x_r, 16'h0);
      cmp("refout", scaled(v), ref_out_r, 16'h1);
    end
    profile_sel = 2'h1;
    for (int k = 0; k < 12; k++)
    begin
      v = 8'($urandom_range(199, 41));
      put(v);
      cmp("linear", lin(v), ref_x_r, 16'h0);
    end
    foreach (tbl[k])
    begin
      profile_sel = tbl[k][17:16];
      put(tbl[k][15:8]);
      cmp("profile", tbl[k][7:0], ref_x_r, 16'h0);
    end
    put(8'h00);
    cmpb("run", 1'b0, motor_run_r);
    standby_device = 1'b1;
    wait_n(8);
    cmp("standby ref", low_off_level, ref_x_r, 16'h0);
    standby_device = 1'b0;
    idle = 1'b0;
    wait_n(150);
    cmpb("early sleep", 1'b0, sleep_r);
    wait_n(100);
    cmpb("sleep", 1'b1, sleep_r);
    idle = 1'b1;
    wait_n(8);
    cmpb("wake", 1'b0, sleep_r);
    cmpb("standby", 1'b1, standby_r);
    source_sel = 2'h1;
    profile_sel = 2'h0;
    run = 1'b1;
    wait_n(400);
    cmp("pwm low", 16'h0, duty_cmd_r, 16'h0);
    for (int k = 0; k < 4; k++)
    begin
      pct = $urandom_range(95, 20);
      hi = 24'(pct);
      wait_n(400);
      cmp("pwm", pwm_exp(pct), duty_cmd_r, 16'h6);
    end
    source_sel = 2'h3;
    range_sel = 2'h1;
    hi = 24'h64;
    per = 24'hc8;
    wait_n(1000);
    cmp("freq max", 16'hff, duty_cmd_r, 16'h0);
    range_sel = 2'h0;
    hi = 24'h7d0;
    per = 24'hfa0;
    wait_n(12000);
    cmp("freq low", 16'h0, duty_cmd_r, 16'h0);
    complete_run;
  end
endmodule // testbench
`default_nettype wire
